/* File: include/pvc_pkg.sv */
// Constants, register map and types for the serial programming controller
package pvc_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int SCK_PERIOD_NS = 125;
   localparam int SCK_HALF_CYC = (SCK_PERIOD_NS * CLK_MHZ + 1999) / 2000;
   localparam int PROG_LOW_NS = 400;
   localparam int PROG_LOW_CYC = (PROG_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int ERASE_WAIT_MS = 5;
   localparam int ERASE_WAIT_CYC = ERASE_WAIT_MS * CLK_MHZ * 1000;
   localparam int KEY_WAIT_MS = 1;
   localparam int KEY_WAIT_CYC = KEY_WAIT_MS * CLK_MHZ * 1000;
   localparam int EXIT_DELAY_NS = 0;
   localparam int EXIT_RAW_CYC = (EXIT_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int EXIT_DELAY_CYC = (EXIT_RAW_CYC < 1) ? 1 : EXIT_RAW_CYC;
   localparam int TMR_W = 20;
   localparam int HC_W = 4;
   // ----------------------------------------------------------------
   // Serial framing
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_EXECUTE = 4'h0;
   localparam logic [3:0] CMD_SHIFT_OUT = 4'h1;
   localparam int CMD_BITS = 4;
   localparam int OPERAND_BITS = 24;
   localparam int IDLE_BITS = 8;
   localparam int DATA_BITS = 16;
   localparam int KEY_BITS = 32;
   localparam int IDX_W = 6;
   // ----------------------------------------------------------------
   // Register offsets (AXI4-Lite byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_OPERAND = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_IMAGE = 8'h0C;
   localparam logic [7:0] OFS_VADDR = 8'h10;
   localparam logic [7:0] OFS_FAILADDR = 8'h14;
   localparam logic [7:0] OFS_CHECKSUM = 8'h18;
   localparam logic [7:0] OFS_IDENT = 8'h1C;
   localparam logic [7:0] OFS_REV = 8'h20;
   localparam logic [7:0] OFS_RDATA = 8'h24;
   // Device-side identity locations, used as operands by software
   localparam logic [23:0] DEV_PART_IDENTITY_ADDR = 24'hFF0000;
   localparam logic [23:0] DEV_SILICON_REV_ADDR = 24'hFF0002;
   // ----------------------------------------------------------------
   // Fields
   // ----------------------------------------------------------------
   localparam int STAT_BUSY = 0;
   localparam int STAT_FAIL = 1;
   localparam int STAT_PHASE = 2;
   localparam int STAT_PROG = 3;
   localparam int FAMILY_LSB = 8;
   localparam int PART_LSB = 0;
   localparam int REV_W = 4;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Configuration masks for the checksum, by selector
   localparam logic [15:0] MASK_SEGMENT_PROTECT = 16'h0003;
   localparam logic [15:0] MASK_OSC_SELECT = 16'h0087;
   localparam logic [15:0] MASK_OSCILLATOR = 16'h00DF;
   localparam logic [15:0] MASK_WATCHDOG = 16'h00DF;
   localparam logic [15:0] MASK_POWER_ON = 16'h00FB;
   localparam logic [15:0] MASK_DEBUG_CHANNEL = 16'h00C3;
   localparam logic [15:0] MASK_DEEP_SLEEP = 16'h00FF;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_ENTER = 2'h0,
      OP_EXECUTE = 2'h1,
      OP_READ = 2'h2,
      OP_EXIT = 2'h3
   } pvc_op_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_PULSE = 3'h1,
      ST_KEYWAIT = 3'h3,
      ST_SHIFT = 3'h2,
      ST_POSTWAIT = 3'h6,
      ST_EXITWAIT = 3'h4
   } pvc_state_type;
   typedef struct packed {
      logic protect;
      logic [2:0] mask_sel;
      logic [1:0] sum_mode;
      logic [1:0] capture;
      logic [1:0] wait_sel;
      pvc_op_type op;
      logic go;
   } pvc_ctrl_type;
endpackage

/* File: core/pvc_host.sv */
// Host-side serial programming controller with AXI4-Lite command port
//
// Operation
// - Verify assembles two read bytes per word
// - Verify right after write when protecting; not sequenced here, verify runs only on reads software issues with capture 1
// - Drop master clear after exit delay
// - Checksum is code plus configuration sum
// - Sum bytes; configuration upper byte ignored
// - Checksum reads zero under read protection
// - Configuration words masked before byte sum
// - Wait five ms after erase
// - Serial clock low 400 ns after programming
// - One ms from master clear to key
// - One ms after key before master clear
// - Command 0001 shifts out readback register
`timescale 1ns/10ps
`default_nettype none
module pvc_host
   import pvc_pkg::*;
#(
   parameter int KEY_WAIT = KEY_WAIT_CYC,
   parameter int ERASE_WAIT = ERASE_WAIT_CYC
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [7:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   output logic master_clear_program_pin_out,
   output logic serial_clock_pin_out,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe_out
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [15:0] mask_of(input logic [2:0] sel);
      case (sel)
         3'h0: mask_of = MASK_SEGMENT_PROTECT;
         3'h1: mask_of = MASK_OSC_SELECT;
         3'h2: mask_of = MASK_OSCILLATOR;
         3'h3: mask_of = MASK_WATCHDOG;
         3'h4: mask_of = MASK_POWER_ON;
         3'h5: mask_of = MASK_DEBUG_CHANNEL;
         3'h6: mask_of = MASK_DEEP_SLEEP;
         default: mask_of = 16'h0000;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   pvc_ctrl_type ctrl;
   pvc_state_type st;
   logic [31:0] operand, image, vaddr, fail_addr;
   logic [15:0] checksum, ident, rx, asm_word;
   logic [REV_W-1:0] rev;
   logic [7:0] asm_lo;
   logic verify_fail, byte_phase, read_done, entering, cmp_pulse;
   logic [31:0] tx;
   logic [IDX_W-1:0] idx, nbits, nout;
   logic [TMR_W-1:0] tmr, post_tmr;
   logic [HC_W-1:0] hc;
   logic sck, prog, din_meta, din_sync;
   logic wr_fire, rd_fire, go_now, is_read, mismatch;
   logic [15:0] masked;

   assign wr_fire = awvalid_in && wvalid_in && !bvalid_out;
   assign rd_fire = arvalid_in && arready_out;
   assign awready_out = wr_fire;
   assign wready_out = wr_fire;
   assign arready_out = !rvalid_out;
   assign go_now = wr_fire && awaddr_in == OFS_CTRL && wstrb_in[0]
      && wdata_in[0] && st == ST_IDLE;
   assign is_read = ctrl.op == OP_READ;
   assign serial_clock_pin_out = sck;
   assign master_clear_program_pin_out = prog;
   assign serial_data_pin_out = tx[0];
   assign serial_data_pin_oe_out = st == ST_SHIFT && idx < nout;
   assign asm_word = {rx[7:0], asm_lo};
   assign mismatch = asm_word != image[15:0];
   assign masked = rx & mask_of(ctrl.mask_sel);

   // ----------------------------------------------------------------
   // Data pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      din_meta <= serial_data_pin_in;
      din_sync <= din_meta;
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         bvalid_out <= 1'b0;
         bresp_out <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_out <= 1'b1;
         bresp_out <= (awaddr_in[1:0] != 2'h0 || awaddr_in > OFS_RDATA)
            ? RESP_SLVERR : RESP_OKAY;
      end else if (bready_in) begin
         bvalid_out <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         rvalid_out <= 1'b0;
         rdata_out <= RESET_WORD;
         rresp_out <= RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_out <= 1'b1;
         rresp_out <= RESP_OKAY;
         case (araddr_in)
            OFS_CTRL: rdata_out <= {19'h0, ctrl};
            OFS_OPERAND: rdata_out <= operand;
            OFS_STATUS: rdata_out <= {28'h0, prog, byte_phase,
               verify_fail, st != ST_IDLE};
            OFS_IMAGE: rdata_out <= image;
            OFS_VADDR: rdata_out <= vaddr;
            OFS_FAILADDR: rdata_out <= fail_addr;
            // Protected parts always sum to zero
            OFS_CHECKSUM: rdata_out <= ctrl.protect ? 32'h0
               : {16'h0, checksum};
            OFS_IDENT: rdata_out <= {16'h0, ident};
            OFS_REV: rdata_out <= {28'h0, rev};
            OFS_RDATA: rdata_out <= {16'h0, rx};
            default: begin
               rdata_out <= RESET_WORD;
               rresp_out <= RESP_SLVERR;
            end
         endcase
      end else if (rready_in) begin
         rvalid_out <= 1'b0;
      end
   end

   // Control, operand and image writes while busy are dropped so an operation never changes mid-run
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ctrl <= '0;
         operand <= RESET_WORD;
         image <= RESET_WORD;
      end else if (wr_fire && st == ST_IDLE) begin
         case (awaddr_in)
            OFS_CTRL: ctrl <= pvc_ctrl_type'(13'(
               merge({19'h0, ctrl}, wdata_in, wstrb_in) & 32'h1FFE));
            OFS_OPERAND: operand <= merge(operand, wdata_in, wstrb_in);
            OFS_IMAGE: image <= merge(image, wdata_in, wstrb_in);
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         st <= ST_IDLE;
         prog <= 1'b0;
         sck <= 1'b0;
         tx <= RESET_WORD;
         rx <= 16'h0;
         idx <= '0;
         nbits <= '0;
         nout <= '0;
         tmr <= '0;
         post_tmr <= '0;
         hc <= '0;
         entering <= 1'b0;
         read_done <= 1'b0;
      end else begin
         read_done <= 1'b0;
         case (st)
            ST_IDLE: begin
               sck <= 1'b0;
               idx <= '0;
               hc <= HC_W'(SCK_HALF_CYC - 1);
               if (go_now) begin
                  case (pvc_op_type'(wdata_in[2:1]))
                     OP_ENTER: begin
                        prog <= 1'b1;
                        tmr <= TMR_W'(SCK_HALF_CYC);
                        st <= ST_PULSE;
                     end
                     OP_EXECUTE: begin
                        tx <= {4'h0, operand[OPERAND_BITS-1:0],
                           CMD_EXECUTE};
                        nbits <= IDX_W'(CMD_BITS + OPERAND_BITS);
                        nout <= IDX_W'(CMD_BITS + OPERAND_BITS);
                        entering <= 1'b0;
                        case (wdata_in[4:3])
                           2'h1: post_tmr <= TMR_W'(PROG_LOW_CYC);
                           2'h2: post_tmr <= TMR_W'(ERASE_WAIT);
                           default: post_tmr <= '0;
                        endcase
                        st <= ST_SHIFT;
                     end
                     OP_READ: begin
                        tx <= {28'h0, CMD_SHIFT_OUT};
                        nbits <= IDX_W'(CMD_BITS + IDLE_BITS + DATA_BITS);
                        nout <= IDX_W'(CMD_BITS);
                        post_tmr <= '0;
                        entering <= 1'b0;
                        st <= ST_SHIFT;
                     end
                     default: begin
                        tmr <= TMR_W'(EXIT_DELAY_CYC);
                        st <= ST_EXITWAIT;
                     end
                  endcase
               end
            end
            ST_PULSE: begin
               if (tmr == '0) begin
                  prog <= 1'b0;
                  tmr <= TMR_W'(KEY_WAIT);
                  st <= ST_KEYWAIT;
               end else begin
                  tmr <= tmr - 1'b1;
               end
            end
            ST_KEYWAIT: begin
               if (tmr == '0) begin
                  // Key goes out most significant bit first
                  tx <= {<<{operand}};
                  nbits <= IDX_W'(KEY_BITS);
                  nout <= IDX_W'(KEY_BITS);
                  post_tmr <= TMR_W'(KEY_WAIT);
                  entering <= 1'b1;
                  st <= ST_SHIFT;
               end else begin
                  tmr <= tmr - 1'b1;
               end
            end
            ST_SHIFT: begin
               if (hc != '0) begin
                  hc <= hc - 1'b1;
               end else if (!sck) begin
                  sck <= 1'b1;
                  hc <= HC_W'(SCK_HALF_CYC - 1);
               end else begin
                  // Sample at the end of the high phase, long after valid
                  sck <= 1'b0;
                  hc <= HC_W'(SCK_HALF_CYC - 1);
                  tx <= {1'b0, tx[31:1]};
                  if (is_read && idx >= IDX_W'(CMD_BITS + IDLE_BITS)) begin
                     rx <= {din_sync, rx[15:1]};
                  end
                  idx <= idx + 1'b1;
                  if (idx == nbits - 1'b1) begin
                     read_done <= is_read && !entering;
                     tmr <= post_tmr;
                     st <= ST_POSTWAIT;
                  end
               end
            end
            ST_POSTWAIT: begin
               if (tmr == '0) begin
                  prog <= prog | entering;
                  entering <= 1'b0;
                  st <= ST_IDLE;
               end else begin
                  tmr <= tmr - 1'b1;
               end
            end
            ST_EXITWAIT: begin
               if (tmr <= TMR_W'(1)) begin
                  prog <= 1'b0;
                  st <= ST_IDLE;
               end else begin
                  tmr <= tmr - 1'b1;
               end
            end
            default: st <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Verify, identity and checksum on each completed read
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         byte_phase <= 1'b0;
         asm_lo <= 8'h0;
         verify_fail <= 1'b0;
         fail_addr <= RESET_WORD;
         vaddr <= RESET_WORD;
         cmp_pulse <= 1'b0;
         ident <= 16'h0;
         rev <= '0;
      end else begin
         cmp_pulse <= 1'b0;
         if (wr_fire && awaddr_in == OFS_STATUS && wstrb_in[0]
               && wdata_in[STAT_FAIL]) begin
            verify_fail <= 1'b0;
         end
         if (wr_fire && awaddr_in == OFS_VADDR) begin
            vaddr <= merge(vaddr, wdata_in, wstrb_in);
            byte_phase <= 1'b0;
         end
         if (read_done) begin
            case (ctrl.capture)
               2'h1: begin
                  if (!byte_phase) begin
                     asm_lo <= rx[7:0];
                     byte_phase <= 1'b1;
                  end else begin
                     byte_phase <= 1'b0;
                     cmp_pulse <= 1'b1;
                     vaddr <= vaddr + 32'h1;
                     if (mismatch) begin
                        verify_fail <= 1'b1;
                        fail_addr <= vaddr;
                     end
                  end
               end
               2'h2: ident <= rx;
               2'h3: rev <= rx[REV_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // Clear and add in one cycle leaves just the new addend
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         checksum <= 16'h0;
      end else begin
         if (read_done) begin
            case (ctrl.sum_mode)
               2'h1: checksum <= (wr_fire && awaddr_in == OFS_CHECKSUM
                  ? 16'h0 : checksum) + {8'h0, rx[7:0]};
               2'h2: checksum <= (wr_fire && awaddr_in == OFS_CHECKSUM
                  ? 16'h0 : checksum) + {8'h0, rx[7:0]}
                  + {8'h0, rx[15:8]};
               2'h3: checksum <= (wr_fire && awaddr_in == OFS_CHECKSUM
                  ? 16'h0 : checksum) + {8'h0, masked[7:0]}
                  + {8'h0, masked[15:8]};
               default: checksum <= (wr_fire && awaddr_in == OFS_CHECKSUM)
                  ? 16'h0 : checksum;
            endcase
         end else if (wr_fire && awaddr_in == OFS_CHECKSUM) begin
            checksum <= 16'h0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_second_byte;
      read_done && ctrl.capture == 2'h1 && byte_phase;
   endsequence
   // Entry pulse also drops the pin; every other fall must be an exit
   sequence s_exit_fall;
      $fell(prog) && $past(st) != ST_PULSE;
   endsequence

   a_key_lead_wait: assert property ((st == ST_KEYWAIT && tmr != '0)
      |=> st == ST_KEYWAIT && !sck)
      else $error("key started before lead wait elapsed");
   a_post_hold: assert property ((st == ST_POSTWAIT && tmr != '0)
      |=> st == ST_POSTWAIT && !sck && !prog == !$past(prog))
      else $error("post wait cut short");
   a_prog_low_time: assert property ((st == ST_SHIFT && idx == nbits
      - 1'b1 && sck && hc == '0 && !is_read && ctrl.wait_sel == 2'h1)
      |=> !sck [*8])
      else $error("serial clock not held low after programming");
   a_exit_order: assert property (s_exit_fall |-> $past(st) ==
      ST_EXITWAIT && !sck && !serial_data_pin_oe_out)
      else $error("master clear dropped with link active");
   a_read_release: assert property ((st == ST_SHIFT && is_read
      && idx >= IDX_W'(CMD_BITS)) |-> !serial_data_pin_oe_out)
      else $error("data pin driven during readback");
   a_byte_pair: assert property (s_second_byte |=> cmp_pulse
      && !byte_phase)
      else $error("word not compared after second byte");
   a_verify_flag: assert property ((s_second_byte ##0 mismatch)
      |=> verify_fail && fail_addr == $past(vaddr))
      else $error("mismatch not flagged with its address");
   a_sum_protect: assert property ((rd_fire && araddr_in == OFS_CHECKSUM
      && ctrl.protect) |=> rdata_out == 32'h0)
      else $error("protected checksum not zero");
   a_ident_split: assert property ((read_done && ctrl.capture == 2'h2)
      |=> ident[15:FAMILY_LSB] == $past(rx[15:8]))
      else $error("identity word not captured");
   a_write_resp: assert property (wr_fire |=> bvalid_out)
      else $error("write not answered");
endmodule
`default_nettype wire

/* File: verif/pvc_dev_model.sv */
// Behavioural target device on the serial programming link
`timescale 1ns/10ps
`default_nettype none
module pvc_dev_model #(
   parameter logic [15:0] ID_WORD = 16'h5A3C, // Arbitrary value
   parameter logic [3:0] REV = 4'h7 // Arbitrary value
) (
   input wire logic prog_in,
   input wire logic sck_in,
   input wire logic pin_in,
   input wire logic protect_in,
   output logic drive_out,
   output logic bit_out
);
   int cnt;
   logic [3:0] cmd;
   logic [23:0] opd;
   logic [23:0] addr;
   logic [15:0] word;
   logic locked;
   always_comb begin
      if (addr == 24'hFF0000) word = ID_WORD;
      else if (addr == 24'hFF0002) word = {12'h000, REV};
      else if (locked) word = 16'h0000;
      else word = {addr[7:0] ^ 8'hC3, addr[7:0] + 8'h11};
   end
   // ------------------------------------------------------------
   // Link framing; released line toggles so no stale level
   // ------------------------------------------------------------
   always @(posedge sck_in or negedge prog_in) begin
      if (!prog_in) begin
         cnt <= 0;
         locked <= protect_in;
         drive_out <= 1'b0;
         bit_out <= 1'b0;
      end else begin
         if (cnt < 4) cmd[cnt] <= pin_in;
         else if (cmd == 4'h0) opd[cnt-4] <= pin_in;
         if (cnt == 27 && cmd == 4'h0) addr <= {pin_in, opd[22:0]};
         drive_out <= cmd == 4'h1 && cnt >= 12;
         bit_out <= (cmd == 4'h1 && cnt >= 12) ? word[cnt-12] : ~bit_out;
         cnt <= (cnt == 27) ? 0 : cnt + 1;
      end
   end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the serial programming controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pvc_pkg::*;
   localparam int KW = 20;
   localparam logic [15:0] ID = 16'h5A3C;
   logic clk_in = 0;
   logic reset_n_in = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   wire awready, wready, bvalid, arready, rvalid, prog, sck, hd, hoe, dd;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire pin = hoe ? hd : dd;
   logic [34:0] expq[$];
   logic [34:0] e;
   logic [15:0] mk [7] = '{MASK_SEGMENT_PROTECT, MASK_OSC_SELECT,
      MASK_OSCILLATOR, MASK_WATCHDOG, MASK_POWER_ON, MASK_DEBUG_CHANNEL,
      MASK_DEEP_SLEEP};
   int failures = 0, compares = 0, cyc = 0, since_f = 0, seed = 42484;
   logic p_sck = 0, p_prog = 0, first = 0, keyed = 0;
   always #5 clk_in = ~clk_in;
   pvc_host #(.KEY_WAIT(KW), .ERASE_WAIT(50)) uut (.clk_in(clk_in),
      .reset_n_in(reset_n_in), .awaddr_in(awaddr), .awvalid_in(awvalid),
      .awready_out(awready), .wdata_in(wdata), .wstrb_in(4'hF),
      .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp),
      .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr),
      .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata),
      .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
      .master_clear_program_pin_out(prog), .serial_clock_pin_out(sck),
      .serial_data_pin_in(pin), .serial_data_pin_out(hd),
      .serial_data_pin_oe_out(hoe));
   pvc_dev_model #(.ID_WORD(ID)) dev (.prog_in(prog), .sck_in(sck),
      .pin_in(pin), .protect_in(1'b0), .drive_out(), .bit_out(dd));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic conclude;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic good, input string m);
      compares++;
      if (good !== 1'b1) begin
         failures++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   function automatic logic [34:0] ok(input logic [31:0] d);
      return {3'b100, d};
   endfunction
   function automatic logic [15:0] mw(input logic [23:0] a);
      return {a[7:0] ^ 8'hC3, a[7:0] + 8'h11};
   endfunction
   function automatic logic [31:0] ctl(input pvc_op_type op,
      input logic [1:0] ws, cap, sm, input logic [2:0] ms);
      pvc_ctrl_type c;
      c = '{1'b0, ms, sm, cap, ws, op, 1'b1};
      return {19'h0, c};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      do @(posedge clk_in); while (!(awready === 1'b1 && wready === 1'b1));
      awvalid <= 0; wvalid <= 0;
      do @(posedge clk_in); while (bvalid !== 1'b1);
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [34:0] x,
      output logic [31:0] d);
      expq.push_back(x);
      @(posedge clk_in);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge clk_in); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge clk_in); while (rvalid !== 1'b1);
      d = rdata;
      rready <= 0;
   endtask
   task automatic run(input logic [31:0] c);
      logic [31:0] s;
      wr(OFS_CTRL, c);
      s = 1;
      while (s[STAT_BUSY] === 1'b1) rd(OFS_STATUS, 35'h0, s);
   endtask
   task automatic at(input logic [23:0] a);
      wr(OFS_OPERAND, {8'h00, a});
      run(ctl(OP_EXECUTE, 0, 0, 0, 0));
   endtask
   // ------------------------------------------------------------
   // Read monitor, link timing watcher and timeout
   // ------------------------------------------------------------
   always @(posedge clk_in)
      if (rvalid === 1'b1 && rready && expq.size() > 0) begin
         e = expq.pop_front();
         if (e[34]) chk({rresp, rdata} === e[33:0], "read value");
      end
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         failures++;
         conclude;
      end
   end
   always @(posedge clk_in) begin
      p_sck <= sck; p_prog <= prog; since_f <= since_f + 1;
      if ((p_sck && !sck) || (p_prog && !prog)) since_f <= 0;
      if (p_prog && !prog) begin
         chk(since_f >= EXIT_DELAY_CYC, "exit delay");
         first <= 1;
      end
      if (!p_sck && sck && first) begin
         chk(since_f >= KW, "key lead");
         first <= 0;
      end
      if (sck && !prog) keyed <= 1;
      if (!p_prog && prog && keyed) begin
         chk(since_f >= KW, "key tail");
         keyed <= 0;
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] s;
      logic [23:0] a1;
      logic [15:0] w1, w2, v, sum, m;
      int t0;
      repeat (5) @(posedge clk_in);
      reset_n_in <= 1;
      rd(8'h28, {1'b1, RESP_SLVERR, 32'h0}, s);
      wr(OFS_OPERAND, $random(seed));
      run(ctl(OP_ENTER, 0, 0, 0, 0));
      at(DEV_PART_IDENTITY_ADDR);
      run(ctl(OP_READ, 0, 2'h2, 0, 0));
      rd(OFS_IDENT, ok({16'h0, ID}), s);
      rd(OFS_RDATA, ok({16'h0, ID}), s);
      at(DEV_SILICON_REV_ADDR);
      run(ctl(OP_READ, 0, 2'h3, 0, 0));
      rd(OFS_REV, ok(32'h7), s);
      a1 = $random(seed) & 24'h0007FC;
      w1 = mw(a1);
      w2 = mw(a1 + 24'h2);
      v = $random(seed) & 16'h7FFF;
      for (int i = 0; i < 2; i++) begin
         wr(OFS_VADDR, {16'h0, v});
         wr(OFS_IMAGE, {16'h0, w2[7:0], w1[7:0] ^ 8'(i)});
         at(a1);
         run(ctl(OP_READ, 0, 2'h1, 0, 0));
         at(a1 + 24'h2);
         run(ctl(OP_READ, 0, 2'h1, 0, 0));
         rd(OFS_STATUS, ok(i ? 32'hA : 32'h8), s);
         rd(OFS_VADDR, ok({16'h0, v + 16'h1}), s);
      end
      rd(OFS_FAILADDR, ok({16'h0, v}), s);
      wr(OFS_STATUS, 32'h2);
      wr(OFS_CHECKSUM, 32'h0);
      at(a1);
      run(ctl(OP_READ, 0, 0, 2'h2, 0));
      run(ctl(OP_READ, 0, 0, 2'h1, 0));
      sum = w1[7:0] + w1[15:8] + w1[7:0];
      for (int i = 0; i < 7; i++) begin
         at(24'hF80000 + 24'(2 * i));
         run(ctl(OP_READ, 0, 0, 2'h3, 3'(i)));
         m = mw(24'hF80000 + 24'(2 * i)) & mk[i];
         sum += m[7:0] + m[15:8];
      end
      rd(OFS_CHECKSUM, ok({16'h0, sum}), s);
      wr(OFS_CTRL, 32'h1000);
      rd(OFS_CHECKSUM, ok(32'h0), s);
      for (int i = 1; i < 3; i++) begin
         t0 = cyc;
         run(ctl(OP_EXECUTE, 2'(i), 0, 0, 0));
         chk(cyc - t0 >= 392 + (i == 1 ? PROG_LOW_CYC : 50), "wait");
      end
      run(ctl(OP_EXIT, 0, 0, 0, 0));
      repeat (4) @(posedge clk_in);
      conclude;
   end
endmodule
`default_nettype wire
